// File: core/tcc_defines.svh
// Offsets, field positions, reset values and counts for the timer count control
// Assumes inclusion by bare name from the design file
`ifndef TCC_DEFINES_SVH
`define TCC_DEFINES_SVH
// ==========================================================
// Register word offsets (byte address = 4 * index)
`define TCC_IDX_CTRL1   4'h0
`define TCC_IDX_CTRL2   4'h1
`define TCC_IDX_CNT1    4'h2
`define TCC_IDX_CNT2    4'h3
`define TCC_IDX_GRA1    4'h4
`define TCC_IDX_GRB1    4'h5
`define TCC_IDX_GRA2    4'h6
`define TCC_IDX_GRB2    4'h7
`define TCC_IDX_RUN     4'h8
`define TCC_IDX_LINK    4'h9
`define TCC_IDX_PINFN   4'hA
// ==========================================================
// Control register fields
`define TCC_CTRL_WMASK  8'h7F
`define TCC_CTRL_RST    8'h00
`define TCC_CLR_HI      6
`define TCC_CLR_LO      5
`define TCC_EDGE_HI     4
`define TCC_EDGE_LO     3
`define TCC_PSC_HI      2
`define TCC_PSC_LO      0
// ==========================================================
// Pin function register: bit0 ch1 A output, bit1 ch2 A output
`define TCC_PINFN_RST   8'h00
`define TCC_CNT_RST     16'h0000
`define TCC_GR_RST      16'hFFFF
`define TCC_PSC_W       10
`endif

// File: core/tcc_pkg.sv
// Types for the timer count control
// Assumes nothing outside itself
package tcc_pkg;
  // Edge choice after decode
  typedef enum logic [1:0] {TCC_RISE, TCC_FALL, TCC_BOTH} tcc_edge_t;
  // Clear source
  typedef enum logic [1:0] {TCC_CLR_NONE, TCC_CLR_A, TCC_CLR_B, TCC_CLR_SYNC} tcc_clr_t;
endpackage

// File: core/tcc_top.sv
// Two channel timer count control with Avalon-MM register slave
// Assumes pin inputs synchronous to clk is not guaranteed for ext clocks
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tcc_defines.svh"

// Functional notes
// - two channels, each with control, counter and two general registers.
// - three external count clock pins A, B and C.
// - pin A captures or drives compare output; pin B only captures.
// - control bit 7 reads zero, writes to it ignored.
// - clear field 00 none, 01 on A match, 10 on B match.
// - clear field 11 clears when a linked channel clears.
// - sync clearing only when the channel's link bit is one.
// - edge field 00 rising, 01 falling, 1X both.
// - both edges on a prescaled clock halve the count period.
// - undivided clock ignores edge field, counts each cycle.
// - prescaler field chooses clock source per channel independently.
// - channel 1 codes: 1,4,16,64,A,B,256, channel 2 overflow.
// - channel 2 codes: 1,4,16,64,A,B,C,1024.
module tcc_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output var  logic [31:0] avs_readdata,
  output var  logic        avs_waitrequest,
  // External count clocks
  input  wire logic        ext_clk_in_a,
  input  wire logic        ext_clk_in_b,
  input  wire logic        ext_clk_in_c,
  // Channel pins
  input  wire logic        ch1_pin_a_in,
  output var  logic        ch1_pin_a_out,
  output var  logic        ch1_pin_a_oe,
  input  wire logic        ch1_pin_b,
  input  wire logic        ch2_pin_a_in,
  output var  logic        ch2_pin_a_out,
  output var  logic        ch2_pin_a_oe,
  input  wire logic        ch2_pin_b
);

  // ==========================================================
  // State
  logic [7:0]  ctrl_r [2];
  logic [15:0] cnt_r [2];
  logic [15:0] gra_r [2];
  logic [15:0] grb_r [2];
  logic [1:0]  run_r;
  logic [1:0]  link_r;
  logic [7:0]  pinfn_r;
  logic [`TCC_PSC_W-1:0] psc_r;
  logic [2:0]  xs1_r, xs2_r, xs3_r;
  logic [1:0]  pa1_r, pa2_r, pa3_r, pb1_r, pb2_r, pb3_r;
  logic        ack_r;

  // Edge select decode
  function automatic tcc_pkg::tcc_edge_t edge_of(input logic [7:0] c);
    if (c[`TCC_EDGE_HI])
      edge_of = tcc_pkg::TCC_BOTH;
    else if (c[`TCC_EDGE_LO])
      edge_of = tcc_pkg::TCC_FALL;
    else
      edge_of = tcc_pkg::TCC_RISE;
  endfunction

  // Count pulse from a level's previous and current sample
  function automatic logic edge_hit(input tcc_pkg::tcc_edge_t e, input logic p, input logic n);
    unique case (e)
      tcc_pkg::TCC_RISE: edge_hit = n & ~p;
      tcc_pkg::TCC_FALL: edge_hit = ~n & p;
      tcc_pkg::TCC_BOTH: edge_hit = n ^ p;
      default:           edge_hit = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // Prescaler free running counter
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      psc_r <= '0;
    else
      psc_r <= psc_r + 1'b1;
  end

  // Pin synchronisers; stage 1 feeds only stage 2
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      xs1_r <= 3'h0;
      xs2_r <= 3'h0;
      xs3_r <= 3'h0;
      pa1_r <= 2'h0;
      pa2_r <= 2'h0;
      pa3_r <= 2'h0;
      pb1_r <= 2'h0;
      pb2_r <= 2'h0;
      pb3_r <= 2'h0;
    end else begin
      xs1_r <= {ext_clk_in_c, ext_clk_in_b, ext_clk_in_a};
      xs2_r <= xs1_r;
      xs3_r <= xs2_r;
      pa1_r <= {ch2_pin_a_in, ch1_pin_a_in};
      pa2_r <= pa1_r;
      pa3_r <= pa2_r;
      pb1_r <= {ch2_pin_b, ch1_pin_b};
      pb2_r <= pb1_r;
      pb3_r <= pb2_r;
    end
  end

  // ==========================================================
  // Count enables per channel
  logic [1:0] tick;
  logic [1:0] ovf;
  logic [1:0] mat_a, mat_b, clr_own;
  logic       sync_clr;

  // Overflow when counting past all ones
  always_comb begin
    for (int i = 0; i < 2; i++)
      ovf[i] = tick[i] & (cnt_r[i] == 16'hFFFF);
  end

  // Source select; channel 2 first so its tick can feed the cascade
  always_comb begin
    for (int i = 1; i >= 0; i--) begin
      logic [2:0] s;
      tcc_pkg::tcc_edge_t e;
      logic lvl_p, lvl_n;
      s = ctrl_r[i][`TCC_PSC_HI:`TCC_PSC_LO];
      e = edge_of(ctrl_r[i]);
      lvl_p = 1'b0;
      lvl_n = 1'b0;
      tick[i] = 1'b0;
      // Divide by 4 period: bit1 toggles every 2 cycles
      unique case (s)
        3'h0: tick[i] = 1'b1;
        3'h1: begin
          lvl_n = psc_r[1];
          lvl_p = ~(psc_r[1] ^ (psc_r[0] == 1'b0));
        end
        default: ;
      endcase
      tick[i] = 1'b0;
      if (s == 3'h0)
        tick[i] = 1'b1;
      else if (s < 3'h4) begin
        // Internal divided clock, edge from prescaler bit transition
        logic [`TCC_PSC_W-1:0] pp;
        int unsigned b;
        pp = psc_r - 1'b1;
        b = 2 * int'(s) - 1;
        tick[i] = edge_hit(e, pp[b], psc_r[b]);
      end else if (i == 0) begin
        unique case (s)
          3'h4: tick[i] = edge_hit(e, xs3_r[0], xs2_r[0]);
          3'h5: tick[i] = edge_hit(e, xs3_r[1], xs2_r[1]);
          3'h6: tick[i] = edge_hit(e, psc_r[7] ^ (psc_r[6:0] == 7'h00), psc_r[7]);
          default: tick[i] = cnt_r[1] == 16'hFFFF && tick[1];
        endcase
      end else begin
        unique case (s)
          3'h4: tick[i] = edge_hit(e, xs3_r[0], xs2_r[0]);
          3'h5: tick[i] = edge_hit(e, xs3_r[1], xs2_r[1]);
          3'h6: tick[i] = edge_hit(e, xs3_r[2], xs2_r[2]);
          default: tick[i] = edge_hit(e, psc_r[9] ^ (psc_r[8:0] == 9'h000), psc_r[9]);
        endcase
      end
      tick[i] = tick[i] & run_r[i];
    end
  end

  // Compare match, capture and clear decision
  always_comb begin
    for (int i = 0; i < 2; i++) begin
      logic cap_a, cap_b;
      cap_a = pinfn_r[i] ? 1'b0 : (pa2_r[i] & ~pa3_r[i]);
      cap_b = pb2_r[i] & ~pb3_r[i];
      mat_a[i] = (tick[i] & cnt_r[i] == gra_r[i]) | cap_a;
      mat_b[i] = (tick[i] & cnt_r[i] == grb_r[i]) | cap_b;
      unique case (tcc_pkg::tcc_clr_t'(ctrl_r[i][`TCC_CLR_HI:`TCC_CLR_LO]))
        tcc_pkg::TCC_CLR_A: clr_own[i] = mat_a[i] & link_r[i] | mat_a[i];
        tcc_pkg::TCC_CLR_B: clr_own[i] = mat_b[i];
        default:            clr_own[i] = 1'b0;
      endcase
    end
  end

  // Any linked channel clearing triggers synchronous clear
  assign sync_clr = |(clr_own & link_r);

  // ==========================================================
  // Counters
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r[0] <= `TCC_CNT_RST;
      cnt_r[1] <= `TCC_CNT_RST;
    end else begin
      for (int i = 0; i < 2; i++) begin
        logic sclr;
        sclr = link_r[i] & sync_clr &
               (ctrl_r[i][`TCC_CLR_HI:`TCC_CLR_LO] == 2'h3);
        if (avs_write && ack_r && avs_address[3:0] == `TCC_IDX_CNT1 + 4'(i))
          cnt_r[i] <= avs_writedata[15:0];
        else if (clr_own[i] || sclr)
          cnt_r[i] <= `TCC_CNT_RST;
        else if (tick[i])
          cnt_r[i] <= cnt_r[i] + 16'h0001;
      end
    end
  end

  // Compare outputs toggle on match while pin is an output
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ch1_pin_a_out <= 1'b0;
      ch2_pin_a_out <= 1'b0;
      ch1_pin_a_oe  <= 1'b0;
      ch2_pin_a_oe  <= 1'b0;
    end else begin
      ch1_pin_a_oe <= pinfn_r[0];
      ch2_pin_a_oe <= pinfn_r[1];
      if (pinfn_r[0] && mat_a[0])
        ch1_pin_a_out <= ~ch1_pin_a_out;
      if (pinfn_r[1] && mat_a[1])
        ch2_pin_a_out <= ~ch2_pin_a_out;
    end
  end

  // ==========================================================
  // Register writes; waitrequest low for one cycle per access
  logic acc;
  assign acc = (avs_read | avs_write) & ~ack_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      ack_r <= 1'b0;
    else
      ack_r <= acc;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r[0] <= `TCC_CTRL_RST;
      ctrl_r[1] <= `TCC_CTRL_RST;
      gra_r[0]  <= `TCC_GR_RST;
      gra_r[1]  <= `TCC_GR_RST;
      grb_r[0]  <= `TCC_GR_RST;
      grb_r[1]  <= `TCC_GR_RST;
      run_r     <= 2'h0;
      link_r    <= 2'h0;
      pinfn_r   <= `TCC_PINFN_RST;
    end else if (avs_write && ack_r) begin
      unique case (avs_address[3:0])
        `TCC_IDX_CTRL1: ctrl_r[0] <= avs_writedata[7:0] & `TCC_CTRL_WMASK;
        `TCC_IDX_CTRL2: ctrl_r[1] <= avs_writedata[7:0] & `TCC_CTRL_WMASK;
        `TCC_IDX_GRA1:  gra_r[0]  <= avs_writedata[15:0];
        `TCC_IDX_GRB1:  grb_r[0]  <= avs_writedata[15:0];
        `TCC_IDX_GRA2:  gra_r[1]  <= avs_writedata[15:0];
        `TCC_IDX_GRB2:  grb_r[1]  <= avs_writedata[15:0];
        `TCC_IDX_RUN:   run_r     <= avs_writedata[1:0];
        `TCC_IDX_LINK:  link_r    <= avs_writedata[1:0];
        `TCC_IDX_PINFN: pinfn_r   <= {6'h00, avs_writedata[1:0]};
        default: ;
      endcase
    end
  end

  // Read data register, unmapped reads zero
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      avs_readdata <= 32'h00000000;
    else if (avs_read && !ack_r) begin
      unique case (avs_address[3:0])
        `TCC_IDX_CTRL1: avs_readdata <= {24'h000000, ctrl_r[0]};
        `TCC_IDX_CTRL2: avs_readdata <= {24'h000000, ctrl_r[1]};
        `TCC_IDX_CNT1:  avs_readdata <= {16'h0000, cnt_r[0]};
        `TCC_IDX_CNT2:  avs_readdata <= {16'h0000, cnt_r[1]};
        `TCC_IDX_GRA1:  avs_readdata <= {16'h0000, gra_r[0]};
        `TCC_IDX_GRB1:  avs_readdata <= {16'h0000, grb_r[0]};
        `TCC_IDX_GRA2:  avs_readdata <= {16'h0000, gra_r[1]};
        `TCC_IDX_GRB2:  avs_readdata <= {16'h0000, grb_r[1]};
        `TCC_IDX_RUN:   avs_readdata <= {30'h00000000, run_r};
        `TCC_IDX_LINK:  avs_readdata <= {30'h00000000, link_r};
        `TCC_IDX_PINFN: avs_readdata <= {24'h000000, pinfn_r};
        default:        avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // Waitrequest high until the cycle after a request arrives
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~acc;
  end

  // ==========================================================
  // Assertions
  property p_ctrl_bit7;
    @(posedge clk) disable iff (!reset_n) ctrl_r[0][7] == 1'b0 && ctrl_r[1][7] == 1'b0;
  endproperty
  a_ctrl_bit7: assert property (p_ctrl_bit7) else $error("control bit 7 set");

  property p_clr_none;
    @(posedge clk) disable iff (!reset_n)
      (ctrl_r[0][6:5] == 2'h0) |-> !clr_own[0];
  endproperty
  a_clr_none: assert property (p_clr_none) else $error("clear with none selected");

  property p_clr_a;
    @(posedge clk) disable iff (!reset_n)
      (ctrl_r[0][6:5] == 2'h1 && mat_a[0] && !(avs_write && ack_r))
      |=> cnt_r[0] == 16'h0000;
  endproperty
  a_clr_a: assert property (p_clr_a) else $error("A match did not clear");

  property p_sync;
    @(posedge clk) disable iff (!reset_n)
      (link_r == 2'h3 && ctrl_r[1][6:5] == 2'h3 && clr_own[0] && !(avs_write && ack_r))
      |=> cnt_r[1] == 16'h0000;
  endproperty
  a_sync: assert property (p_sync) else $error("sync clear missed");

  property p_nolink;
    @(posedge clk) disable iff (!reset_n)
      (link_r[1] == 1'b0) |-> !sync_clr || !clr_own[1] || link_r[0];
  endproperty
  a_nolink: assert property (p_nolink) else $error("unlinked sync clear");

  property p_div1;
    @(posedge clk) disable iff (!reset_n)
      (run_r[0] && ctrl_r[0][2:0] == 3'h0) |-> tick[0];
  endproperty
  a_div1: assert property (p_div1) else $error("div1 must tick each cycle");

  property p_stop;
    @(posedge clk) disable iff (!reset_n) !run_r[1] |-> !tick[1];
  endproperty
  a_stop: assert property (p_stop) else $error("tick while stopped");

  property p_wait;
    @(posedge clk) disable iff (!reset_n)
      (avs_read && avs_waitrequest) |=> !avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("no answer in one cycle");

  c_ovf:  cover property (@(posedge clk) disable iff (!reset_n) ovf[1]);
  c_sync: cover property (@(posedge clk) disable iff (!reset_n) sync_clr);
  c_out:  cover property (@(posedge clk) disable iff (!reset_n) $rose(ch1_pin_a_out));

endmodule
`default_nettype wire

// File: testbench/tcc_ext_src.sv
// External count clock source for the timer count control bench
// Assumes bursts are requested by one process at a time
`timescale 1ns/1ps
`default_nettype none
module tcc_ext_src (
  // Clock
  input  wire logic clk,
  // External count clocks
  output var  logic ext_clk_in_a,
  output var  logic ext_clk_in_b,
  output var  logic ext_clk_in_c
);
  // ==========================================================
  // Pins stand low between bursts
  initial begin
    ext_clk_in_a = 1'b0;
    ext_clk_in_b = 1'b0;
    ext_clk_in_c = 1'b0;
  end
  // Pulse burst on one of three pins, half period in clk cycles
  task automatic burst(input int sel, input int n, input int half);
    for (int i = 0; i < 2 * n; i++) begin
      @(posedge clk);
      if (sel == 0) ext_clk_in_a <= ~ext_clk_in_a;
      else if (sel == 1) ext_clk_in_b <= ~ext_clk_in_b;
      else ext_clk_in_c <= ~ext_clk_in_c;
      repeat (half - 1) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking bench for the timer count control
// Assumes the two cycle register access and word map of the top module
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================================
  // Signals, model and tables
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  adr = 6'h00;
  logic        rd_en = 1'b0;
  logic        wr_en = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic        wreq;
  wire logic   ea, eb, ec;
  logic        a1_out, a1_oe, a2_out, a2_oe, a1_q, a2_q;
  int          toggles2 = 0;
  int          n_errors = 0;
  int          tests_run = 0;
  int          toggles = 0;
  int          mdl [16];
  logic [31:0] rng = 32'h00006373;
  logic [31:0] v, w;
  int          g1, g2, n;
  localparam int         PCH [15] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1};
  localparam logic [7:0] PCT [15] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06, 8'h09, 8'h11,
                                      8'h19, 8'h10, 8'h00, 8'h01, 8'h02, 8'h03, 8'h07, 8'h12};
  localparam int         PEX [15] = '{2048, 512, 128, 32, 8, 512, 1024, 1024, 2048,
                                      2048, 512, 128, 32, 2, 256};
  localparam int         ECH [6]  = '{0, 0, 1, 1, 1, 0};
  localparam logic [7:0] ECT [6]  = '{8'h04, 8'h05, 8'h04, 8'h0D, 8'h16, 8'h1C};
  localparam int         ESL [6]  = '{0, 1, 0, 1, 2, 0};
  localparam int         EML [6]  = '{1, 1, 1, 1, 2, 2};
  // Clock
  always #50 clk = ~clk;
  // Count ch1 compare output changes and ch2 compare output rising edges
  always @(posedge clk) begin
    a1_q <= a1_out;
    if (a1_q !== a1_out) toggles <= toggles + 1;
    a2_q <= a2_out;
    if (a2_q === 1'b0 && a2_out === 1'b1) toggles2 <= toggles2 + 1;
  end
  // ==========================================================
  // Design and far side
  tcc_top i_dut (
    .clk(clk), .reset_n(reset_n), .avs_address(adr), .avs_read(rd_en), .avs_write(wr_en),
    .avs_writedata(wdat), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .ext_clk_in_a(ea), .ext_clk_in_b(eb), .ext_clk_in_c(ec),
    .ch1_pin_a_in(1'b0), .ch1_pin_a_out(a1_out), .ch1_pin_a_oe(a1_oe), .ch1_pin_b(1'b0),
    .ch2_pin_a_in(1'b0), .ch2_pin_a_out(a2_out), .ch2_pin_a_oe(a2_oe), .ch2_pin_b(1'b0)
  );
  tcc_ext_src i_src (.clk(clk), .ext_clk_in_a(ea), .ext_clk_in_b(eb), .ext_clk_in_c(ec));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus access, held until wait request is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int k;
    @(posedge clk);
    adr <= {2'b00, a};
    wr_en <= wr;
    rd_en <= ~wr;
    wdat <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    q = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      $display("bus wait timed out");
      final_report();
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d, w);
    if (a < 4'h2) mdl[a] = int'(d & 32'h0000007F);
    else if (a < 4'h8) mdl[a] = int'(d & 32'h0000FFFF);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, q);
  endtask
  // Counts on one channel for a window or an external burst
  task automatic cnt_run(input int ch, input logic [7:0] ctl, input int cyc, input int sel,
                         input int np, output logic [31:0] q);
    wr(4'(ch), {24'h000000, ctl});
    wr(4'(ch + 2), 32'h00000000);
    wr(4'h8, 32'(ch + 1));
    if (np > 0) i_src.burst(sel, np, 3 + 4 * (np % 2));
    repeat (cyc) @(posedge clk);
    wr(4'h8, 32'h00000000);
    rd(4'(ch + 2), q);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge clk);
    reset_n <= 1'b1;
    for (int k = 0; k < 16; k++) mdl[k] = (k >= 4 && k < 8) ? 32'h0000FFFF : 0;
    // Reset values, then random writes incl. reserved bit and unmapped words
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 16; k++) if (r > 0 && (k < 8 || k > 10)) wr(4'(k), rnd());
      for (int k = 0; k < 16; k++) begin
        if (k < 8 || k > 10) begin
          rd(4'(k), v);
          check("register", v, 32'(mdl[k]));
        end
      end
    end
    $display("test registers done");
    for (int k = 0; k < 15; k++) begin
      cnt_run(PCH[k], PCT[k], 2048, 0, 0, v);
      check("prescaled count", 32'(v + 2 >= PEX[k] && v <= PEX[k] + 5), 1);
    end
    $display("test prescaler done");
    for (int k = 0; k < 6; k++) begin
      n = 3 + int'(rnd() % 6);
      cnt_run(ECH[k], ECT[k], 8, ESL[k], n, v);
      check("external count", v, 32'(n * EML[k]));
    end
    $display("test external clocks done");
    g1 = 40 + int'(rnd() % 32);
    g2 = 100 + int'(rnd() % 32);
    wr(4'h4, 32'(g1));
    wr(4'h5, 32'(g2));
    wr(4'h7, 32'(g2));
    wr(4'hA, 32'h00000001);
    repeat (2) @(posedge clk);
    check("pin drive", {30'h0, a2_oe, a1_oe}, 32'h00000001);
    for (int m = 0; m < 3; m++) begin
      toggles = 0;
      cnt_run(0, 8'(m << 5), 400, 0, 0, v);
      check("clear source", 32'(m == 0 ? v > 300 : v <= (m == 1 ? g1 : g2)), 1);
    end
    check("compare output", 32'(toggles >= 2), 1);
    cnt_run(1, 8'h40, 400, 0, 0, v);
    check("clear source", 32'(v <= g2), 1);
    wr(4'hA, 32'h00000002);
    repeat (2) @(posedge clk);
    check("pin drive", {30'h0, a2_oe, a1_oe}, 32'h00000002);
    wr(4'h6, 32'(g1));
    cnt_run(1, 8'h40, 600, 0, 0, v);
    check("compare output 2", 32'(toggles2 >= 1), 1);
    $display("test clear sources done");
    wr(4'h0, 32'h00000020);
    wr(4'h1, 32'h00000060);
    for (int l = 3; l > 0; l = l - 2) begin
      wr(4'h9, 32'(l));
      wr(4'h2, 32'h00000000);
      wr(4'h3, 32'h00000000);
      wr(4'h8, 32'h00000003);
      repeat (300) @(posedge clk);
      wr(4'h8, 32'h00000000);
      rd(4'h2, v);
      rd(4'h3, w);
      check("linked clear", 32'(l == 3 ? (w == v && v <= g1) : w > 200), 1);
    end
    $display("test linked clear done");
    wr(4'h1, 32'h00000000);
    wr(4'h0, 32'h00000007);
    wr(4'h3, 32'h0000FFF0);
    wr(4'h2, 32'h00000000);
    wr(4'h8, 32'h00000003);
    repeat (60) @(posedge clk);
    wr(4'h8, 32'h00000000);
    rd(4'h2, v);
    check("overflow count", v, 32'h00000001);
    $display("test overflow chain done");
    final_report();
  end
endmodule
`default_nettype wire
